// File: merb_record_bank.sv
// Error record bank: one memory error record with capture, summary and interrupt
//
// Notes on behaviour
// - A 32-bit read-write counter of uncorrectable errors resets to zero.
// - The feature register is read-only and returns the global feature record value.
// - The control register is reserved, read-only and always reads zero.
// - The status register holds record valid, uncorrectable and overflow flags, read-write.
// - Address capture one holds bank in 31:28, row in 27:10, column in 9:0.
// - Address capture two holds rank in 2:0, stack select in 5:3, reserved above.
// - The first location capture holds rank, row and column of the first error.
// - The second capture holds bank, logical rank and buffer id of the first error.
// - The summary register has one field per record copying its valid bit.
// - Every register is readable and the writable ones writable in any state.
`timescale 1ns/1ps
`include "merb_map.svh"

module merb_record_bank #(
  // Position of this record's field in the summary word
  parameter int RECORD_INDEX = `MERB_SUMMARY_V_BIT
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Global records and error capture from the controller
  input  wire logic [31:0] global_feature_record,
  input  wire logic        err_valid,
  input  wire logic        err_uncorrectable,
  input  wire logic [3:0]  err_bank,
  input  wire logic [17:0] err_row,
  input  wire logic [9:0]  err_column,
  input  wire logic [2:0]  err_rank,
  input  wire logic [2:0]  err_stack_select,
  input  wire logic [2:0]  err_logical_rank,
  input  wire logic [7:0]  err_buffer_id,
  // Interrupt
  output logic             irq
);
  import merb_pkg::*;

  // Register map of this record, byte offsets
  //   0x868  uncorrectable error count, read-write
  //   0x880  feature mirror, read-only copy of the global record
  //   0x888  control, reserved, reads zero, writes ignored
  //   0x890  error status, read-write
  //   0x898  bank, row and column of the captured error
  //   0x89c  stack select and rank of the captured error
  //   0x8a0  rank, row and column of the first error since a clear
  //   0x8a4  bank, logical rank and buffer id of that first error
  //   0x920  summary, one valid copy per record, writes ignored
  //   0x930  interrupt causes, write one to clear
  //   0x934  interrupt mask, same layout as the causes
  //
  // Error status word
  //   bit 30  record valid, set by a capture, cleared by software
  //   bit 29  the captured error was uncorrectable
  //   bit 27  another error arrived while the record was held
  //   other   plain storage for software
  //   Clearing valid frees the record for the next error.
  //
  // Capture words, all four loaded together by one capture
  //   0x898  bank 31:28, row 27:10, column 9:0
  //   0x89c  stack select 5:3, rank 2:0, bits 31:6 kept zero
  //   0x8a0  rank 31:29, row 28:11, zero at 10, column 9:0
  //   0x8a4  buffer id 14:7, logical rank 6:4, bank 3:0, zero above
  //
  // Interrupt causes
  //   bit 0  an error was captured into a free record
  //   bit 1  an error met a held record
  //   A cause raised in the cycle of its clear stays set.
  //   The interrupt line is high while any unmasked cause is set.
  //
  // Bus behaviour
  //   Write address and data are taken in either order.
  //   A write lands one cycle after both halves are held.
  //   Its response then stands until bready is seen.
  //   A read answers one cycle after its address is taken.
  //   One write and one read at most are under way at a time.
  //   Unmapped addresses answer SLVERR and change nothing.
  //   Writes to read-only places answer OKAY and change nothing.
  //
  // Limitations
  //   One record only; an error that meets a held record is counted if uncorrectable
  //   and flags overflow, but its location is not kept.
  //   Clearing valid in the cycle of a new error drops its location;
  //   its overflow cause is still raised.
  //   The count wraps to zero past its top value.
  //   The mirror follows the global record one cycle late.
  //   Interrupt causes and mask use only their low two bits.
  //   Byte strobes apply to every writable register except the mask, which an unstrobed low byte clears.

  merb_state_type st_r;
  merb_state_type st_nxt;

  logic [31:0] wmask;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;
  logic        do_write;
  logic        captured;
  logic        ovf_event;
  logic [31:0] cap_addr0;
  logic [31:0] cap_addr1;
  logic [31:0] cap_loc;
  logic [31:0] cap_bank;

  // Byte-lane mask from write strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{st_r.wstrb[i]}};
    end
  end

  // Read decode; unmapped addresses answer SLVERR with zero data
  always_comb begin
    rd_val = `MERB_ZERO;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `MERB_UNCORR_COUNT_OFF: rd_val = st_r.uncorr_count;
      `MERB_FEATURE_OFF:      rd_val = st_r.feature;
      `MERB_CONTROL_OFF:      rd_val = `MERB_ZERO;
      `MERB_STATUS_OFF:       rd_val = st_r.status;
      `MERB_ADDR0_OFF:        rd_val = st_r.addr0;
      `MERB_ADDR1_OFF:        rd_val = st_r.addr1;
      `MERB_FIRST_LOC_OFF:    rd_val = st_r.first_loc;
      `MERB_FIRST_BANK_OFF:   rd_val = st_r.first_bank;
      `MERB_SUMMARY_OFF:      rd_val = st_r.summary;
      `MERB_IRQ_STATUS_OFF:   rd_val = {30'h0, st_r.irq_status};
      `MERB_IRQ_MASK_OFF:     rd_val = {30'h0, st_r.irq_mask};
      default:                rd_ok  = 1'b0;
    endcase
  end

  // Write decode; read-only registers accept and ignore, unmapped gets SLVERR
  always_comb begin
    unique case (st_r.awaddr)
      `MERB_UNCORR_COUNT_OFF, `MERB_FEATURE_OFF, `MERB_CONTROL_OFF, `MERB_STATUS_OFF,
      `MERB_ADDR0_OFF, `MERB_ADDR1_OFF, `MERB_FIRST_LOC_OFF, `MERB_FIRST_BANK_OFF,
      `MERB_SUMMARY_OFF, `MERB_IRQ_STATUS_OFF, `MERB_IRQ_MASK_OFF: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Captures happen only while no earlier error is held
  assign captured  = err_valid && !st_r.status[`MERB_STATUS_V_BIT];
  assign ovf_event = err_valid && st_r.status[`MERB_STATUS_V_BIT];
  assign do_write  = st_r.wstate == MERB_B_IDLE && st_r.aw_held && st_r.w_held;

  // Capture words in register layout, each exactly one word wide
  assign cap_addr0 = {err_bank, err_row, err_column};
  assign cap_addr1 = {26'h0, err_stack_select, err_rank};
  assign cap_loc   = {err_rank, err_row, 1'h0, err_column};
  assign cap_bank  = {17'h0, err_buffer_id, err_logical_rank, err_bank};

  // Next state: bus handshake, register writes, error capture, interrupt
  always_comb begin
    st_nxt = st_r;
    wr_val = st_r.wdata & wmask;

    // Mirror is registered so rdata stays a flop output
    st_nxt.feature = global_feature_record;

    // Address and data are taken independently, each held until used
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.awaddr  = s_axi_awaddr;
      st_nxt.aw_held = 1'b1;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
      st_nxt.w_held = 1'b1;
      st_nxt.wready = 1'b0;
    end

    // Software writes, in any controller state
    if (do_write) begin
      unique case (st_r.awaddr)
        `MERB_UNCORR_COUNT_OFF:
          st_nxt.uncorr_count = (st_r.uncorr_count & ~wmask) | wr_val;
        `MERB_STATUS_OFF:
          st_nxt.status = (st_r.status & ~wmask) | wr_val;
        `MERB_ADDR0_OFF:
          st_nxt.addr0 = (st_r.addr0 & ~wmask) | wr_val;
        `MERB_ADDR1_OFF:
          st_nxt.addr1 = (st_r.addr1 & ~wmask) | (wr_val & `MERB_ADDR1_MASK);
        `MERB_FIRST_LOC_OFF:
          st_nxt.first_loc = (st_r.first_loc & ~wmask) | wr_val;
        `MERB_FIRST_BANK_OFF:
          st_nxt.first_bank = (st_r.first_bank & ~wmask) | wr_val;
        `MERB_IRQ_STATUS_OFF:
          st_nxt.irq_status = st_r.irq_status & ~wr_val[1:0];
        `MERB_IRQ_MASK_OFF:
          st_nxt.irq_mask = wr_val[1:0];
        default: begin
        end
      endcase
      st_nxt.bresp   = wr_ok ? 2'b00 : 2'b10;
      st_nxt.bvalid  = 1'b1;
      st_nxt.wstate  = MERB_B_RESP;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
    end

    // Response done, reopen both channels
    if (st_r.wstate == MERB_B_RESP && s_axi_bready) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.wstate  = MERB_B_IDLE;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // Hardware capture after software, so a same-cycle event wins
    if (err_valid && err_uncorrectable) begin
      st_nxt.uncorr_count = st_nxt.uncorr_count + 32'h00000001;
    end
    if (captured) begin
      st_nxt.status[`MERB_STATUS_V_BIT]  = 1'h1;
      st_nxt.status[`MERB_STATUS_UE_BIT] = err_uncorrectable;
      st_nxt.addr0      = cap_addr0;
      st_nxt.addr1      = cap_addr1;
      st_nxt.first_loc  = cap_loc;
      st_nxt.first_bank = cap_bank;
    end
    if (ovf_event) begin
      st_nxt.status[`MERB_STATUS_OF_BIT] = 1'b1;
    end

    // Summary mirrors this record's valid bit, overriding any write
    st_nxt.summary = `MERB_ZERO;
    st_nxt.summary[RECORD_INDEX] = st_nxt.status[`MERB_STATUS_V_BIT];

    // Sticky interrupt causes; set beats a write-one clear
    if (captured) begin
      st_nxt.irq_status[`MERB_IRQ_ERR_BIT] = 1'b1;
    end
    if (ovf_event) begin
      st_nxt.irq_status[`MERB_IRQ_OVF_BIT] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);

    // Read channel: one read at a time
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = rd_val;
      st_nxt.rresp   = rd_ok ? 2'b00 : 2'b10;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.wstate  <= MERB_B_IDLE;
      st_r.awready <= 1'b1;
      st_r.wready  <= 1'b1;
      st_r.arready <= 1'b1;
      // Readies come up high so the first request is taken at once
      st_r.feature <= `MERB_FEATURE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign irq           = st_r.irq;
endmodule // merb_record_bank

// File: merb_map.svh
// Register offsets, field positions and reset values of the error record bank
`ifndef MERB_MAP_SVH
`define MERB_MAP_SVH
`define MERB_UNCORR_COUNT_OFF  12'h868
`define MERB_FEATURE_OFF       12'h880
`define MERB_CONTROL_OFF       12'h888
`define MERB_STATUS_OFF        12'h890
`define MERB_ADDR0_OFF         12'h898
`define MERB_ADDR1_OFF         12'h89c
`define MERB_FIRST_LOC_OFF     12'h8a0
`define MERB_FIRST_BANK_OFF    12'h8a4
`define MERB_SUMMARY_OFF       12'h920
`define MERB_IRQ_STATUS_OFF    12'h930
`define MERB_IRQ_MASK_OFF      12'h934
`define MERB_FEATURE_RST       32'h000009aa
`define MERB_ZERO              32'h00000000
`define MERB_STATUS_V_BIT      30
`define MERB_STATUS_UE_BIT     29
`define MERB_STATUS_OF_BIT     27
`define MERB_SUMMARY_V_BIT     6
`define MERB_ADDR1_MASK        32'h0000003f
`define MERB_IRQ_ERR_BIT       0
`define MERB_IRQ_OVF_BIT       1
`define MERB_IRQ_MASK_W        32'h00000003
`endif

// File: merb_pkg.sv
// Types shared by the error record bank
package merb_pkg;
  typedef enum logic [1:0] {
    MERB_B_IDLE,
    MERB_B_RESP
  } merb_wstate_type;

  typedef struct packed {
    merb_wstate_type wstate;
    logic            awready;
    logic            wready;
    logic            aw_held;
    logic            w_held;
    logic [11:0]     awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [31:0]     uncorr_count;
    logic [31:0]     status;
    logic [31:0]     addr0;
    logic [31:0]     addr1;
    logic [31:0]     first_loc;
    logic [31:0]     first_bank;
    logic [31:0]     summary;
    logic [1:0]      irq_status;
    logic [1:0]      irq_mask;
    logic            irq;
    logic [31:0]     feature;
  } merb_state_type;
endpackage

// File: merb_record_bank_checker.sv
// Bus timing and fixed read values of the error record bank
`timescale 1ns/1ps
`include "merb_map.svh"
module merb_record_bank_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken on one edge
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken for one place
  sequence s_rtake(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  AST_B_LAT: assert property (s_wtake |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  AST_CTL_ZERO: assert property (s_rtake(`MERB_CONTROL_OFF) |=>
    s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0) else $error("control not zero");
  AST_ADDR1_RSV: assert property (s_rtake(`MERB_ADDR1_OFF) |=>
    s_axi_rdata[31:6] == 26'h0) else $error("reserved bits set");
  AST_SUM_ONE: assert property (s_rtake(`MERB_SUMMARY_OFF) |=>
    (s_axi_rdata & ~32'h40) == 32'h0) else $error("summary extra bits");
  AST_UNMAP: assert property (s_rtake(12'h900) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule // merb_record_bank_checker

bind merb_record_bank merb_record_bank_checker u_chk (.*);

// File: merb_record_bank_test.sv
// Self-checking bench of the error record bank
`timescale 1ns/1ps
`include "merb_map.svh"
module merb_record_bank_test;
  import merb_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, global_feature_record = '0;
  logic [3:0] s_axi_wstrb = 4'hf, err_bank = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, err_valid = 1'h0;
  logic err_uncorrectable = 1'h0;
  logic [17:0] err_row = '0;
  logic [9:0] err_column = '0;
  logic [2:0] err_rank = '0, err_stack_select = '0, err_logical_rank = '0;
  logic [7:0] err_buffer_id = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int err_count = 0, checks_done = 0, seed = 32'h90da0cb0;
  // Model of every register the bench can see
  logic [31:0] m_cnt = '0, m_st = '0, m_a0 = '0, m_a1 = '0, m_loc = '0, m_bnk = '0;
  logic [1:0] m_iq = '0, m_mk = '0;
  logic [31:0] wd = '0;

  merb_record_bank u_dut (.*);

  always #20 aclk = ~aclk;

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, g);
    end
  endtask
  // Both halves offered together, each dropped once taken
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk($sformatf("read %h", a), e, s_axi_rdata);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // Random write; the model keeps only the bits that stick
  task automatic rw(logic [11:0] a, logic [31:0] wm, logic [31:0] em, output logic [31:0] m);
    logic [31:0] x;
    x = $random(seed) & wm;
    wr(a, x, 2'h0);
    m = x & em;
  endtask
  // Settle the level interrupt, then read back every state register except the feature mirror
  task automatic regs;
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, |(m_iq & m_mk)}, {31'h0, irq});
    rd(`MERB_UNCORR_COUNT_OFF, m_cnt, 2'h0);
    rd(`MERB_STATUS_OFF, m_st, 2'h0);
    rd(`MERB_ADDR0_OFF, m_a0, 2'h0);
    rd(`MERB_ADDR1_OFF, m_a1, 2'h0);
    rd(`MERB_FIRST_LOC_OFF, m_loc, 2'h0);
    rd(`MERB_FIRST_BANK_OFF, m_bnk, 2'h0);
    rd(`MERB_SUMMARY_OFF, {25'h0, m_st[30], 6'h0}, 2'h0);
    rd(`MERB_IRQ_STATUS_OFF, {30'h0, m_iq}, 2'h0);
    rd(`MERB_IRQ_MASK_OFF, {30'h0, m_mk}, 2'h0);
  endtask
  // One error pulse; a held record flags overflow and its cause but keeps its location
  task automatic hit(logic ue);
    logic [31:0] x, y;
    x = $random(seed);
    y = $random(seed);
    @(posedge aclk);
    err_valid <= 1'h1;
    err_uncorrectable <= ue;
    {err_bank, err_row, err_column} <= x;
    {err_rank, err_stack_select, err_logical_rank, err_buffer_id} <= y[16:0];
    @(posedge aclk);
    err_valid <= 1'h0;
    m_cnt = m_cnt + {31'h0, ue};
    if (m_st[30]) begin
      m_st[27] = 1'h1;
      m_iq[1] = 1'h1;
    end else begin
      m_st[30] = 1'h1;
      m_st[29] = ue;
      m_iq[0] = 1'h1;
      m_a0 = x;
      m_a1 = {26'h0, y[13:11], y[16:14]};
      m_loc = {y[16:14], x[27:10], 1'h0, x[9:0]};
      m_bnk = {17'h0, y[7:0], y[10:8], x[31:28]};
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, far beyond the run's few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim();
  end

  initial begin
    global_feature_record <= $random(seed);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    regs();
    rd(`MERB_FEATURE_OFF, global_feature_record, 2'h0);
    rd(`MERB_CONTROL_OFF, 32'h0, 2'h0);
    wr(`MERB_FEATURE_OFF, 32'hffffffff, 2'h0);
    wr(`MERB_CONTROL_OFF, 32'hffffffff, 2'h0);
    wr(`MERB_SUMMARY_OFF, 32'hffffffff, 2'h0);
    wr(12'h900, 32'h1, 2'h2);
    rd(12'h900, 32'h0, 2'h2);
    rd(`MERB_FEATURE_OFF, global_feature_record, 2'h0);
    $display("test reset and read-only done");
    rw(`MERB_UNCORR_COUNT_OFF, '1, '1, m_cnt);
    wd = $random(seed);
    s_axi_wstrb <= 4'h5;
    wr(`MERB_UNCORR_COUNT_OFF, wd, 2'h0);
    s_axi_wstrb <= 4'hf;
    m_cnt = (m_cnt & 32'hff00ff00) | (wd & 32'h00ff00ff);
    rw(`MERB_ADDR0_OFF, '1, '1, m_a0);
    rw(`MERB_ADDR1_OFF, '1, `MERB_ADDR1_MASK, m_a1);
    rw(`MERB_FIRST_LOC_OFF, '1, '1, m_loc);
    rw(`MERB_FIRST_BANK_OFF, '1, '1, m_bnk);
    rw(`MERB_STATUS_OFF, 32'h97ffffff, '1, m_st);
    regs();
    $display("test write and read back done");
    m_mk = 2'h3;
    wr(`MERB_IRQ_MASK_OFF, 32'h3, 2'h0);
    hit(1'h1);
    regs();
    hit(1'h1);
    hit(1'h0);
    regs();
    m_iq = 2'h0;
    wr(`MERB_IRQ_STATUS_OFF, 32'h3, 2'h0);
    m_mk = 2'h0;
    wr(`MERB_IRQ_MASK_OFF, 32'h0, 2'h0);
    m_st = 32'h0;
    wr(`MERB_STATUS_OFF, 32'h0, 2'h0);
    regs();
    hit(1'h0);
    regs();
    m_mk = 2'h1;
    wr(`MERB_IRQ_MASK_OFF, 32'h1, 2'h0);
    regs();
    $display("test capture and interrupt done");
    end_sim();
  end
endmodule // merb_record_bank_test
